// *** inc/bank_select_refresh_config_map.vh ***
// Register map, field layout and timing constants of the bank select and refresh block
`ifndef BANK_SELECT_REFRESH_CONFIG_MAP_VH
`define BANK_SELECT_REFRESH_CONFIG_MAP_VH
`define ADDR_GLOBAL     8'h00
`define ADDR_FLAGS      8'h04
`define ADDR_BANK_BASE  8'h40
`define ADDR_BANK_LAST  8'h7c
`define GMR_RESET       32'h0000_0000
`define BR_RESET        32'h0000_0000
`define OR_RESET        32'h0000_0000
`define G_REFRESH_INTERVAL_COUNT_HI      31
`define G_REFRESH_INTERVAL_COUNT_LO      24
`define G_REFRESH_ENABLE_BIT          23
`define G_REFRESH_CYCLE_LENGTH_HI       22
`define G_REFRESH_CYCLE_LENGTH_LO       21
`define G_PGS_HI        20
`define G_PGS_LO        18
`define G_DPS_HI        17
`define G_DPS_LO        16
`define G_DWQ           15
`define G_EXTERNAL_MASTER_WAIT          14
`define G_SYNC          13
`define G_INTERNAL_ADDR_MULTIPLEXING          12
`define B_BA_HI         27
`define B_BA_LO         11
`define B_FC_HI         10
`define B_FC_LO         7
`define B_BANK_PARITY_ENABLE         3
`define B_WP            1
`define B_V             0
`define O_BANK_WAIT_STATES_HI       31
`define O_BANK_WAIT_STATES_LO       28
`define O_FCM_HI        10
`define O_FCM_LO        7
`define O_PAGE_MODE_ENABLE          3
`define O_SPS_HI        2
`define O_SPS_LO        1
`define O_DRAM_BANK_SELECT         0
`define F_WPE           0
`define F_PER           1
`define WIDTH_32        2'b00
`define WIDTH_8         2'b01
`define WIDTH_16        2'b10
`define CPU_SPACE       3'b111
`define REF_PRESCALE    8'd15
`define REF_BIAS        8'd2
`define REFRESH_CYCLE_LENGTH_BASE       3'd2
`define PAGE_MIN_SHIFT  5'd9
`endif

// *** core/bank_select_refresh_config.v ***
// Bank decode, wait control, refresh timer and APB register file of the memory controller
`timescale 1ns/1ps
`include "bank_select_refresh_config_map.vh"
module bank_select_refresh_config
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        address_strobe_n,
	input  wire        master_read,
	input  wire [31:0] master_addr,
	input  wire [3:0]  master_fc,
	input  wire [31:0] master_data,
	input  wire [3:0]  master_parity,
	output wire [7:0]  bank_select_n,
	output wire [1:0]  bus_size_acknowledge_n,
	output wire        refresh_active,
	output wire        internal_addr_multiplexing,
	output wire        page_hit
);
	localparam S_IDLE = 4'b0001;
	localparam S_WAIT = 4'b0010;
	localparam S_ACK  = 4'b0100;
	localparam S_END  = 4'b1000;

	reg  [31:0] global_memory_config_ff;
	reg  [1:0]  memory_error_flags_ff;
	reg  [31:0] bank_base_setup_ff [0:7];
	reg  [31:0] bank_option_setup_ff [0:7];
	reg  [3:0]  state_ff;
	reg  [3:0]  nxt_state;
	reg  [4:0]  wait_ff;
	reg  [4:0]  nxt_wait;
	reg  [7:0]  sel_n_ff;
	reg  [7:0]  nxt_sel_n;
	reg  [1:0]  ack_n_ff;
	reg  [1:0]  nxt_ack_n;
	reg  [2:0]  bank_ff;
	reg  [2:0]  nxt_bank;
	reg  [31:0] page_ff;
	reg         page_valid_ff;
	reg         page_hit_ff;
	reg         as_fall_ff;
	reg         as_sync_ff;
	reg  [7:0]  pre_ff;
	reg  [7:0]  ivl_ff;
	reg  [2:0]  refresh_cycle_length_ff;
	reg         hit_any;
	reg  [2:0]  hit_idx;
	reg  [7:0]  hit;
	reg  [1:0]  width;
	reg  [4:0]  waits;
	reg         wp_err;
	reg         par_err;
	reg         this_page;
	reg  [31:0] page_mask;
	integer     i;
	// Own index for the reset loop, so the decode loop index has one driver
	integer     k;

	wire        sync_mode = global_memory_config_ff[`G_SYNC];
	wire [31:0] global_memory_config = global_memory_config_ff;
	wire [31:0] br  = bank_base_setup_ff[hit_idx];
	wire [31:0] opt = bank_option_setup_ff[hit_idx];
	wire        wr_acc = psel & penable & pwrite;
	wire        rd_setup = psel & ~penable & ~pwrite;
	wire        bank_area = paddr >= `ADDR_BANK_BASE && paddr <= `ADDR_BANK_LAST;
	wire        mapped = paddr == `ADDR_GLOBAL || paddr == `ADDR_FLAGS || bank_area;
	wire [2:0]  pidx = paddr[5:3];
	wire        as_n;
	wire        tick;
	wire        cycle_start;
	wire [3:0]  bad_par;

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign bank_select_n = sel_n_ff;
	assign bus_size_acknowledge_n = ack_n_ff;
	assign refresh_active = refresh_cycle_length_ff != 3'd0;
	assign internal_addr_multiplexing = global_memory_config[`G_INTERNAL_ADDR_MULTIPLEXING];
	assign page_hit = page_hit_ff;

	// Strobe path: direct when clocked, else falling-edge then rising-edge stage
	always @(negedge pclk or negedge presetn)
	begin
		if (!presetn)
			as_fall_ff <= 1'b1;
		else
			as_fall_ff <= address_strobe_n;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			as_sync_ff <= 1'b1;
		else
			as_sync_ff <= as_fall_ff;
	end

	// A negation shorter than a clock may be missed here
	assign as_n = sync_mode ? address_strobe_n : as_sync_ff;

	// Bank decode; lowest matching bank wins when areas overlap
	always @*
	begin
		hit_any = 1'b0;
		hit_idx = 3'd0;
		for (i = 0; i < 8; i = i + 1)
		begin
			hit[i] = bank_base_setup_ff[i][`B_V]
				&& ((master_addr[`B_BA_HI:`B_BA_LO] ^ bank_base_setup_ff[i][`B_BA_HI:`B_BA_LO])
				& bank_option_setup_ff[i][`B_BA_HI:`B_BA_LO]) == 17'h0_0000
				&& ((master_fc ^ bank_base_setup_ff[i][`B_FC_HI:`B_FC_LO])
				& ~bank_option_setup_ff[i][`O_FCM_HI:`O_FCM_LO]) == 4'h0
				&& master_fc[2:0] != `CPU_SPACE;
		end
		for (i = 7; i >= 0; i = i - 1)
		begin
			if (hit[i])
			begin
				hit_any = 1'b1;
				hit_idx = i[2:0];
			end
		end
	end

	// Port width, wait count, page compare and error checks for the hit bank
	always @*
	begin
		if (opt[`O_DRAM_BANK_SELECT])
			width = global_memory_config[`G_DPS_HI:`G_DPS_LO];
		else
			width = opt[`O_SPS_HI:`O_SPS_LO];
		page_mask = 32'hffff_ffff << (`PAGE_MIN_SHIFT + {2'b00, global_memory_config[`G_PGS_HI:`G_PGS_LO]});
		this_page = page_valid_ff && bank_ff == hit_idx
			&& (master_addr & page_mask) == page_ff
			&& opt[`O_DRAM_BANK_SELECT] && opt[`O_PAGE_MODE_ENABLE];
		if (this_page)
			waits = {4'h0, global_memory_config[`G_DWQ]};
		else
			waits = {1'b0, opt[`O_BANK_WAIT_STATES_HI:`O_BANK_WAIT_STATES_LO]};
		if (!sync_mode && global_memory_config[`G_EXTERNAL_MASTER_WAIT] && !this_page)
			waits = waits + 5'd1;
		wp_err = !master_read && br[`B_WP];
		par_err = master_read && br[`B_BANK_PARITY_ENABLE] && sync_mode && bad_par != 4'h0;
	end

	// Odd parity per byte lane
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : lane
			assign bad_par[g] = ~^{master_data[8*g+7:8*g], master_parity[g]};
		end
	endgenerate

	assign cycle_start = state_ff == S_IDLE && !as_n && hit_any;

	// Bus cycle sequencer
	always @*
	begin
		nxt_state = state_ff;
		nxt_wait  = wait_ff;
		nxt_sel_n = sel_n_ff;
		nxt_ack_n = ack_n_ff;
		nxt_bank  = bank_ff;
		case (state_ff)
			S_IDLE:
			begin
				if (cycle_start)
				begin
					nxt_sel_n = ~(8'h01 << hit_idx);
					nxt_bank  = hit_idx;
					nxt_wait  = waits;
					if (wp_err)
						nxt_state = S_END;
					else if (waits == 5'd0)
						nxt_state = S_ACK;
					else
						nxt_state = S_WAIT;
				end
			end
			S_WAIT:
			begin
				nxt_wait = wait_ff - 5'd1;
				if (wait_ff == 5'd1)
					nxt_state = S_ACK;
				if (as_n)
				begin
					nxt_state = S_IDLE;
					nxt_sel_n = 8'hff;
				end
			end
			S_ACK:
			begin
				case (width)
					`WIDTH_8:  nxt_ack_n = 2'b10;
					`WIDTH_16: nxt_ack_n = 2'b01;
					default:   nxt_ack_n = 2'b00;
				endcase
				nxt_state = S_END;
			end
			S_END:
			begin
				if (as_n)
				begin
					nxt_state = S_IDLE;
					nxt_sel_n = 8'hff;
					nxt_ack_n = 2'b11;
				end
			end
			default:
			begin
				nxt_state = S_IDLE;
				nxt_sel_n = 8'hff;
				nxt_ack_n = 2'b11;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff      <= S_IDLE;
			wait_ff       <= 5'd0;
			sel_n_ff      <= 8'hff;
			ack_n_ff      <= 2'b11;
			bank_ff       <= 3'd0;
			page_ff       <= 32'h0000_0000;
			page_valid_ff <= 1'b0;
			page_hit_ff   <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			wait_ff  <= nxt_wait;
			sel_n_ff <= nxt_sel_n;
			ack_n_ff <= nxt_ack_n;
			bank_ff  <= nxt_bank;
			if (cycle_start)
			begin
				page_hit_ff   <= this_page;
				page_ff       <= master_addr & page_mask;
				page_valid_ff <= 1'b1;
			end
			// A refresh closes every open row, so no page hit after it
			if (refresh_active)
				page_valid_ff <= 1'b0;
		end
	end

	// Refresh timer: period is (count + bias) * prescale clocks
	assign tick = pre_ff == 8'd0;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pre_ff  <= 8'd0;
			ivl_ff  <= 8'd0;
			refresh_cycle_length_ff <= 3'd0;
		end
		else
		begin
			if (!global_memory_config[`G_REFRESH_ENABLE_BIT] || tick)
				pre_ff <= `REF_PRESCALE - 8'd1;
			else
				pre_ff <= pre_ff - 8'd1;
			if (!global_memory_config[`G_REFRESH_ENABLE_BIT])
				ivl_ff <= global_memory_config[`G_REFRESH_INTERVAL_COUNT_HI:`G_REFRESH_INTERVAL_COUNT_LO] + `REF_BIAS - 8'd1;
			else if (tick)
			begin
				if (ivl_ff == 8'd0)
					ivl_ff <= global_memory_config[`G_REFRESH_INTERVAL_COUNT_HI:`G_REFRESH_INTERVAL_COUNT_LO] + `REF_BIAS - 8'd1;
				else
					ivl_ff <= ivl_ff - 8'd1;
			end
			if (global_memory_config[`G_REFRESH_ENABLE_BIT] && tick && ivl_ff == 8'd0)
				refresh_cycle_length_ff <= `REFRESH_CYCLE_LENGTH_BASE + {1'b0, global_memory_config[`G_REFRESH_CYCLE_LENGTH_HI:`G_REFRESH_CYCLE_LENGTH_LO]};
			else if (refresh_active)
				refresh_cycle_length_ff <= refresh_cycle_length_ff - 3'd1;
		end
	end

	// Register file; error set wins over a same-cycle clear
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			global_memory_config_ff <= `GMR_RESET;
			memory_error_flags_ff   <= 2'b00;
			for (k = 0; k < 8; k = k + 1)
			begin
				bank_base_setup_ff[k]   <= `BR_RESET;
				bank_option_setup_ff[k] <= `OR_RESET;
			end
		end
		else
		begin
			if (wr_acc && paddr == `ADDR_GLOBAL)
				global_memory_config_ff <= pwdata;
			if (wr_acc && bank_area && !paddr[2])
				bank_base_setup_ff[pidx] <= pwdata;
			if (wr_acc && bank_area && paddr[2])
				bank_option_setup_ff[pidx] <= pwdata;
			memory_error_flags_ff[`F_WPE] <= (cycle_start && wp_err)
				|| (memory_error_flags_ff[`F_WPE]
				&& !(wr_acc && paddr == `ADDR_FLAGS && pwdata[`F_WPE]));
			memory_error_flags_ff[`F_PER] <= (cycle_start && !wp_err && par_err)
				|| (memory_error_flags_ff[`F_PER]
				&& !(wr_acc && paddr == `ADDR_FLAGS && pwdata[`F_PER]));
		end
	end

	// Read data captured in the setup phase
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_setup)
		begin
			if (paddr == `ADDR_GLOBAL)
				prdata <= global_memory_config_ff;
			else if (paddr == `ADDR_FLAGS)
				prdata <= {30'h0000_0000, memory_error_flags_ff};
			else if (bank_area && !paddr[2])
				prdata <= bank_base_setup_ff[pidx];
			else if (bank_area)
				prdata <= bank_option_setup_ff[pidx];
			else
				prdata <= 32'h0000_0000;
		end
	end
endmodule

// *** test/bank_select_refresh_config_asserts.sv ***
// Port checks of the bank select and refresh block
`timescale 1ns/1ps
module bsrc_checker
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       address_strobe_n,
	input wire logic [7:0] bank_select_n,
	input wire logic [1:0] bus_size_acknowledge_n,
	input wire logic       refresh_active
);
	wire unmap = paddr != 8'h00 && paddr != 8'h04 && (paddr < 8'h40 || paddr > 8'h7c);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_high: assert property (pready)
		else $error("pready low");
	chk_slverr_map: assert property (psel && penable && paddr[1:0] == 2'b00 |-> pslverr == unmap)
		else $error("pslverr wrong");
	chk_select_onehot: assert property ($onehot0(~bank_select_n))
		else $error("two selects");
	chk_select_cause: assert property (bank_select_n != 8'hff && $past(bank_select_n) == 8'hff
		|-> !$past(address_strobe_n))
		else $error("select without strobe");
	chk_ack_select: assert property (bus_size_acknowledge_n != 2'b11
		|-> bank_select_n != 8'hff && $past(bank_select_n) != 8'hff)
		else $error("ack before select");
	chk_strobe_release: assert property (address_strobe_n [*4]
		|-> bank_select_n == 8'hff && bus_size_acknowledge_n == 2'b11)
		else $error("select held");
	chk_refresh_min: assert property ($rose(refresh_active) |=> refresh_active)
		else $error("refresh too short");
	chk_ack_hold: assert property (bus_size_acknowledge_n != 2'b11 && !address_strobe_n
		|=> $stable(bus_size_acknowledge_n))
		else $error("ack dropped");
endmodule
bind bank_select_refresh_config bsrc_checker chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .address_strobe_n(address_strobe_n),
	.bank_select_n(bank_select_n), .bus_size_acknowledge_n(bus_size_acknowledge_n),
	.refresh_active(refresh_active));

// *** test/bus_master_model.sv ***
// Behavioural external bus master running strobe cycles
`timescale 1ns/1ps
module bus_master_model
(
	input  wire logic        pclk,
	input  wire logic [7:0]  bank_select_n,
	input  wire logic [1:0]  bus_size_acknowledge_n,
	output logic             address_strobe_n = 1'b1,
	output logic             master_read = 1'b1,
	output logic [31:0]      master_addr = 32'h0,
	output logic [3:0]       master_fc = 4'h0,
	output logic [31:0]      master_data = 32'h0,
	output logic [3:0]       master_parity = 4'h0
);
	task automatic cycle(input logic r, input logic [31:0] a, input logic [3:0] f, input logic b,
		output int lat, output logic [1:0] ak);
		int n;
		logic [31:0] d;
		d = $urandom;
		lat = 0;
		ak = 2'b11;
		@(posedge pclk);
		address_strobe_n <= 1'b0;
		master_read <= r;
		master_addr <= a;
		master_fc <= f;
		master_data <= d;
		master_parity <= {~^d[31:24], ~^d[23:16], ~^d[15:8], ~^d[7:0]} ^ {3'b000, b};
		// Refused cycles get no ack, so give up after a bound
		for (n = 1; n <= 24 && lat == 0; n++)
		begin
			@(posedge pclk);
			if (bus_size_acknowledge_n !== 2'b11)
			begin
				lat = n;
				ak = bus_size_acknowledge_n;
			end
		end
		address_strobe_n <= 1'b1;
		master_data <= ~d;
		for (n = 0; n < 8 && bank_select_n !== 8'hff; n++)
			@(posedge pclk);
		@(posedge pclk);
	endtask
endmodule

// *** test/bank_select_refresh_config_bench.sv ***
// Self-checking bench of the bank select and refresh block
`timescale 1ns/1ps
`include "bank_select_refresh_config_map.vh"
module bank_select_refresh_config_bench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, a_m, d_m;
	logic [7:0]  sel_n, sel_old = 8'hff;
	logic [3:0]  fc_m, par_m;
	logic [1:0]  ack_n, ak;
	logic        pready, pslverr, as_n, rd_m, rfa, imux, hit;
	logic [31:0] rq[$];
	logic [7:0]  sq[$];
	logic [31:0] bt[4] = '{32'h0040_0000, 32'h0010_0001, 32'h0020_0003, 32'h0030_0009};
	int          fail_count = 0, checked = 0, lat, l0, la, i;
	always #25 pclk = ~pclk;
	bank_select_refresh_config bank_select_refresh_config_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .address_strobe_n(as_n), .master_read(rd_m), .master_addr(a_m), .master_fc(fc_m),
		.master_data(d_m), .master_parity(par_m), .bank_select_n(sel_n), .bus_size_acknowledge_n(ack_n),
		.refresh_active(rfa), .internal_addr_multiplexing(imux), .page_hit(hit));
	bus_master_model bus_master_model_inst (.pclk(pclk), .bank_select_n(sel_n), .bus_size_acknowledge_n(ack_n),
		.address_strobe_n(as_n), .master_read(rd_m), .master_addr(a_m), .master_fc(fc_m),
		.master_data(d_m), .master_parity(par_m));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n == 0 || (pready !== 1'b1 && n < 20); n++)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			fail_count++;
			end_of_test();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic mc(input logic r, input logic [31:0] a, input logic [3:0] f, input logic b, input logic [7:0] e);
		if (e !== 8'hff)
			sq.push_back(e);
		bus_master_model_inst.cycle(r, a, f, b, lat, ak);
	endtask
	task automatic lvl(input logic v, output int n);
		for (n = 0; rfa !== v; n++)
		begin
			@(posedge pclk);
			if (n > 1000)
			begin
				fail_count++;
				end_of_test();
			end
		end
	endtask
	task automatic refresh(input logic [7:0] c);
		int hi, lo;
		apb(1'b1, `ADDR_GLOBAL, {c, 24'ha0_2000});
		lvl(1'b0, hi);
		lvl(1'b1, hi);
		lvl(1'b0, hi);
		lvl(1'b1, lo);
		chk(hi, 3);
		chk(hi + lo, (c + 2) * 15);
		$display("refresh count %0d done", c);
	endtask
	always @(posedge pclk)
	begin
		if (psel && penable && !pwrite && pready)
			chk(prdata, rq.size() ? rq.pop_front() : 32'hx);
		if (presetn && sel_old === 8'hff && sel_n !== 8'hff)
			chk({24'h0, sel_n}, {24'h0, sq.size() ? sq.pop_front() : 8'hxx});
		sel_old <= sel_n;
	end
	initial
	begin
		void'($urandom(36488));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(`ADDR_GLOBAL, `GMR_RESET);
		rd(`ADDR_FLAGS, 32'h0);
		for (i = 0; i < 16; i++)
			rd(8'h40 + 8'(4 * i), `BR_RESET);
		rd(8'h20, 32'h0);
		$display("reset values done");
		apb(1'b1, `ADDR_GLOBAL, 32'h180c_1000);
		rd(`ADDR_GLOBAL, 32'h180c_1000);
		@(negedge pclk);
		chk(imux, 1);
		apb(1'b1, `ADDR_GLOBAL, 32'h0000_2000);
		@(negedge pclk);
		chk(imux, 0);
		for (i = 0; i < 4; i++)
		begin
			apb(1'b1, 8'h40 + 8'(8 * i), bt[i]);
			apb(1'b1, 8'h44 + 8'(8 * i), 32'h0ff0_0780);
			rd(8'h40 + 8'(8 * i), bt[i]);
		end
		$display("global and bank setup done");
		mc(1'b1, 32'h0010_0000 | ($urandom & 32'h000f_fffc), 4'h5, 1'b0, 8'hfd);
		chk(ak, 2'b00);
		l0 = lat;
		mc(1'b1, 32'h0040_0010, 4'h5, 1'b0, 8'hff);
		chk(lat, 0);
		mc(1'b1, 32'h0010_0010, 4'h7, 1'b0, 8'hff);
		chk(lat, 0);
		mc(1'b1, 32'h0090_0000, 4'h5, 1'b0, 8'hff);
		chk(lat, 0);
		mc(1'b1, 32'h001f_fffc, 4'hd, 1'b0, 8'hfd);
		chk(lat, l0);
		apb(1'b1, 8'h4c, 32'h3ff0_0780);
		mc(1'b1, 32'h0010_0040, 4'h5, 1'b0, 8'hfd);
		chk(lat, l0 + 3);
		for (i = 1; i < 3; i++)
		begin
			apb(1'b1, 8'h4c, 32'h0ff0_0780 | (i << 1));
			mc(1'b1, 32'h0010_0080, 4'h5, 1'b0, 8'hfd);
			chk(ak, i == 1 ? 2'b10 : 2'b01);
		end
		apb(1'b1, 8'h4c, 32'h0ff0_0780);
		$display("decode and waits done");
		apb(1'b1, `ADDR_GLOBAL, 32'h0000_6000);
		mc(1'b1, 32'h0010_0100, 4'h5, 1'b0, 8'hfd);
		chk(lat, l0);
		apb(1'b1, `ADDR_GLOBAL, 32'h0000_0000);
		mc(1'b1, 32'h0010_0100, 4'h5, 1'b0, 8'hfd);
		la = lat;
		chk(la > l0, 1);
		mc(1'b1, 32'h0030_0000, 4'h5, 1'b1, 8'hf7);
		rd(`ADDR_FLAGS, 32'h0);
		apb(1'b1, `ADDR_GLOBAL, 32'h0000_4000);
		mc(1'b1, 32'h0010_0100, 4'h5, 1'b0, 8'hfd);
		chk(lat, la + 1);
		$display("bus modes done");
		apb(1'b1, `ADDR_GLOBAL, 32'h0000_2000);
		mc(1'b0, 32'h0020_0100, 4'h5, 1'b0, 8'hfb);
		chk(lat, 0);
		mc(1'b0, 32'h0010_0100, 4'h5, 1'b0, 8'hfd);
		rd(`ADDR_FLAGS, 32'h1);
		apb(1'b1, `ADDR_FLAGS, 32'h1);
		mc(1'b1, 32'h0010_0000, 4'h5, 1'b1, 8'hfd);
		rd(`ADDR_FLAGS, 32'h0);
		mc(1'b1, 32'h0030_0000, 4'h5, 1'b1, 8'hf7);
		rd(`ADDR_FLAGS, 32'h2);
		apb(1'b1, `ADDR_FLAGS, 32'h2);
		rd(`ADDR_FLAGS, 32'h0);
		$display("error flags done");
		apb(1'b1, `ADDR_GLOBAL, 32'h0000_a000);
		apb(1'b1, 8'h4c, 32'h3ff0_0789);
		mc(1'b1, 32'h0010_0200, 4'h5, 1'b0, 8'hfd);
		chk(lat, l0 + 3);
		chk(hit, 0);
		mc(1'b1, 32'h0010_0204, 4'h5, 1'b0, 8'hfd);
		chk(lat, l0 + 1);
		chk(hit, 1);
		chk(ak, 2'b00);
		mc(1'b1, 32'h0010_0400, 4'h5, 1'b0, 8'hfd);
		chk(lat, l0 + 3);
		chk(hit, 0);
		$display("page mode done");
		refresh(8'd0);
		refresh(8'd24);
		chk(rq.size() + sq.size(), 0);
		end_of_test();
	end
endmodule
